// ===== ssp_top.sv
// Synchronous serial port core: bus slave, link shifter, master clock
//
// Functional notes
// - Master reception starts on single or continuous enable; no clocks before.
// - Nine bit select gives nine bit characters, otherwise eight.
// - Completed character sets receive flag; request only with receive enable.
// - Data read returns low eight bits of oldest unread character.
// - Overrun cleared by clearing continuous enable or port enable.
// - Sync select one is synchronous; clock source zero makes a slave.
// - Slave transmits with both receive enables clear, else receives; needs enable.
// - Slave transmit behaves as master transmit, clock taken from pin.
// - Two writes: first shifts out, second held, buffer flag stays clear.
// - After first shifts out, held one loads and buffer flag sets.
// - Buffer flag wakes with peripheral and transmit enables; handler needs global.
// - Slave receive acts continuous; single enable alone also receives there and is never cleared.
// - Slave character received in sleep reaches queue and may wake.
// - Single receive gives one character of clocks then clears itself.
// - Continuous cleared mid character stops clock and drops partial character.
// - Two character queue; third character sets overrun, keeps data, blocks.
// - Data changes on leading edge, sampled on trailing; one bit per clock.
`timescale 1ns/1ps
module ssp_top import ssp_pkg::*; (
   input  wire logic        hclk,
   input  wire logic        hresetn,
   input  wire logic        hsel,
   input  wire logic [31:0] haddr,
   input  wire logic [1:0]  htrans,
   input  wire logic        hwrite,
   input  wire logic [2:0]  hsize,
   input  wire logic [31:0] hwdata,
   input  wire logic        hready,
   output logic             hreadyout,
   output logic [31:0]      hrdata,
   output logic             hresp,
   input  wire logic        ck_i,
   output logic             ck_o,
   output logic             ck_oe,
   input  wire logic        dt_i,
   output logic             dt_o,
   output logic             dt_oe,
   output logic             wake_o,
   output logic             irq_o
);
   ssp_fifo_if q ();

   logic              ap_v_q, ap_v_d, ap_wr_q, ap_wr_d, rd_done_q, rd_done_d;
   logic [7:0]        ap_addr_q, ap_addr_d, hrdata_q, hrdata_d, rd_mux;
   logic [7:0]        tx_ctl_q, tx_ctl_d, rx_ctl_q, rx_ctl_d, baud_q, baud_d;
   logic [15:0]       div_q, div_d, divcnt_q, divcnt_d;
   logic [3:0]        ien_q, ien_d, bitcnt_q, bitcnt_d, rx_last, tx_last;
   logic [CHAR_W-1:0] hold_q, hold_d, tsr_q, tsr_d, rsr_q, rsr_d, rx_full, rx_char;
   logic              hold_v_q, hold_v_d, busy_q, busy_d, started_q, started_d;
   logic              overrun_error_flag_q, overrun_error_flag_d, mck_q, mck_d, rx_done;
   logic              ck_s1_q, ck_s2_q, ck_s3_q, dt_s1_q, dt_s2_q;
   logic              wr_commit, rd_phase, rd_pop, tx_write, serial_port_enable, sync_on, master;
   logic              single_char_rx_enable, continuous_rx_enable, rx_mode, rx_go, tx_mode, gen_run, div_tick;
   logic              lead, trail, rx_complete_flag, tx_buffer_free_flag;

   ////////////////////////////////////////////////////////////////////////////////
   // Bus slave: writes complete at once, reads take one wait cycle
   assign wr_commit = ap_v_q & ap_wr_q;
   assign rd_phase  = ap_v_q & ~ap_wr_q & ~rd_done_q;
   assign rd_pop    = rd_phase & (ap_addr_q == OFS_RX_DATA) & ~q.empty;
   assign tx_write  = wr_commit & (ap_addr_q == OFS_TX_DATA);
   assign hreadyout = ~rd_phase;
   assign hresp     = 1'b0;
   assign hrdata    = {24'h000000, hrdata_q};

   // Read data selection
   always_comb begin
      rd_mux = 8'h00;
      if (ap_addr_q == OFS_TX_STATUS) begin
         rd_mux               = tx_ctl_q;
         rd_mux[TX_TSR_EMPTY] = ~busy_q;
      end else if (ap_addr_q == OFS_RX_STATUS) begin
         rd_mux           = rx_ctl_q;
         rd_mux[RX_OVERRUN_ERROR_FLAG]  = overrun_error_flag_q;
         rd_mux[RX_NINTH] = q.head[8];
      end else if (ap_addr_q == OFS_BAUD_CTRL) begin
         rd_mux             = baud_q;
         rd_mux[BC_RX_IDLE] = ~rx_go;
      end else if (ap_addr_q == OFS_DIV_LO) begin
         rd_mux = div_q[7:0];
      end else if (ap_addr_q == OFS_DIV_HI) begin
         rd_mux = div_q[15:8];
      end else if (ap_addr_q == OFS_RX_DATA) begin
         rd_mux = q.head[7:0];
      end else if (ap_addr_q == OFS_IRQ_CTRL) begin
         rd_mux        = {4'h0, ien_q};
         rd_mux[IF_RX] = rx_complete_flag;
         rd_mux[IF_TX] = tx_buffer_free_flag;
      end
   end

   // Address phase capture and read data register
   always_comb begin
      ap_v_d    = ap_v_q;
      ap_wr_d   = ap_wr_q;
      ap_addr_d = ap_addr_q;
      rd_done_d = rd_phase;
      hrdata_d  = rd_phase ? rd_mux : hrdata_q;
      if (hready) begin
         ap_v_d    = hsel & htrans[1];
         ap_wr_d   = hwrite;
         ap_addr_d = {haddr[7:2], 2'b00};
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         ap_v_q    <= 1'b0;
         ap_wr_q   <= 1'b0;
         ap_addr_q <= 8'h00;
         rd_done_q <= 1'b0;
         hrdata_q  <= 8'h00;
      end else begin
         ap_v_q    <= ap_v_d;
         ap_wr_q   <= ap_wr_d;
         ap_addr_q <= ap_addr_d;
         rd_done_q <= rd_done_d;
         hrdata_q  <= hrdata_d;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Link pin synchronisers
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         ck_s1_q <= 1'b0;
         ck_s2_q <= 1'b0;
         ck_s3_q <= 1'b0;
         dt_s1_q <= 1'b0;
         dt_s2_q <= 1'b0;
      end else begin
         ck_s1_q <= ck_i;
         ck_s2_q <= ck_s1_q;
         ck_s3_q <= ck_s2_q;
         dt_s1_q <= dt_i;
         dt_s2_q <= dt_s1_q;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Mode decode
   assign serial_port_enable    = rx_ctl_q[RX_SERIAL_PORT_ENABLE];
   assign sync_on = serial_port_enable & tx_ctl_q[TX_SYNC];
   assign master  = tx_ctl_q[TX_MCS];
   assign single_char_rx_enable    = rx_ctl_q[RX_SINGLE_CHAR_RX_ENABLE];
   assign continuous_rx_enable    = rx_ctl_q[RX_CONTINUOUS_RX_ENABLE];
   assign rx_mode = sync_on & (single_char_rx_enable | continuous_rx_enable);
   assign rx_go   = rx_mode & ~overrun_error_flag_q;
   assign tx_mode = sync_on & ~(single_char_rx_enable | continuous_rx_enable) & tx_ctl_q[TX_EN];
   assign rx_last = rx_ctl_q[RX_NINE] ? LAST_WIDE : LAST_NARROW;
   assign tx_last = tx_ctl_q[TX_NINE] ? LAST_WIDE : LAST_NARROW;
   assign rx_full = {dt_s2_q, rsr_q[8:1]};
   assign rx_char = rx_ctl_q[RX_NINE] ? rx_full : {1'b0, rx_full[8:1]};

   // Master clock runs only while a character is due; edges from pin otherwise
   assign gen_run  = master & (rx_go | (tx_mode & busy_q));
   assign div_tick = gen_run & (divcnt_q == div_q);
   assign lead     = master ? (div_tick & ~mck_q) : (ck_s2_q & ~ck_s3_q);
   assign trail    = master ? (div_tick & mck_q) : (~ck_s2_q & ck_s3_q);

   // Pins and flags
   assign ck_o   = mck_q;
   assign ck_oe  = sync_on & master;
   assign dt_o   = tsr_q[0];
   assign dt_oe  = tx_mode;
   assign rx_complete_flag   = ~q.empty;
   assign tx_buffer_free_flag   = ~hold_v_q;
   assign wake_o = ien_q[IE_PERI] & ((ien_q[IE_RX] & rx_complete_flag) | (ien_q[IE_TX] & tx_buffer_free_flag));
   assign irq_o  = wake_o & ien_q[IE_GLOBAL];

   assign q.pop   = rd_pop;
   assign q.flush = ~serial_port_enable;
   assign q.wdata = rx_char;
   assign q.push  = rx_done & (~q.full | rd_pop);

   ////////////////////////////////////////////////////////////////////////////////
   // Registers, shifters and clock generator: next values
   always_comb begin
      tx_ctl_d  = tx_ctl_q;
      rx_ctl_d  = rx_ctl_q;
      baud_d    = baud_q;
      div_d     = div_q;
      ien_d     = ien_q;
      hold_d    = hold_q;
      hold_v_d  = hold_v_q;
      tsr_d     = tsr_q;
      busy_d    = busy_q;
      started_d = started_q;
      bitcnt_d  = bitcnt_q;
      rsr_d     = rsr_q;
      overrun_error_flag_d    = overrun_error_flag_q;
      mck_d     = mck_q;
      divcnt_d  = divcnt_q;
      rx_done   = 1'b0;
      // Software writes
      if (wr_commit) begin
         if (ap_addr_q == OFS_TX_STATUS) begin
            tx_ctl_d = hwdata[7:0] & TX_WR_MASK;
         end else if (ap_addr_q == OFS_RX_STATUS) begin
            rx_ctl_d = hwdata[7:0] & RX_WR_MASK;
         end else if (ap_addr_q == OFS_BAUD_CTRL) begin
            baud_d = hwdata[7:0] & BAUD_WR_MASK;
         end else if (ap_addr_q == OFS_DIV_LO) begin
            div_d[7:0] = hwdata[7:0];
         end else if (ap_addr_q == OFS_DIV_HI) begin
            div_d[15:8] = hwdata[7:0];
         end else if (ap_addr_q == OFS_TX_DATA) begin
            hold_d   = {tx_ctl_q[TX_NINTH], hwdata[7:0]};
            hold_v_d = 1'b1;
         end else if (ap_addr_q == OFS_IRQ_CTRL) begin
            ien_d = hwdata[3:0];
         end
      end
      // Overrun clears: continuous enable dropped, or data read in single mode
      if (continuous_rx_enable & ~rx_ctl_d[RX_CONTINUOUS_RX_ENABLE]) begin
         overrun_error_flag_d = 1'b0;
      end
      if (rd_pop & ~continuous_rx_enable) begin
         overrun_error_flag_d = 1'b0;
      end
      // Master clock divider; idle low when stopped
      if (gen_run) begin
         if (div_tick) begin
            divcnt_d = 16'h0000;
            mck_d    = ~mck_q;
         end else begin
            divcnt_d = divcnt_q + 16'h0001;
         end
      end else begin
         divcnt_d = 16'h0000;
         mck_d    = 1'b0;
      end
      // Transmit and receive shifters
      if (tx_mode) begin
         if (!busy_q) begin
            if (hold_v_q) begin
               tsr_d     = hold_q;
               busy_d    = 1'b1;
               started_d = 1'b0;
               bitcnt_d  = 4'h0;
               if (!tx_write) begin
                  hold_v_d = 1'b0;
               end
            end
         end else begin
            if (lead) begin
               if (started_q) begin
                  tsr_d = {1'b0, tsr_q[8:1]};
               end
               started_d = 1'b1;
            end
            if (trail && started_q) begin
               if (bitcnt_q == tx_last) begin
                  busy_d   = 1'b0;
                  bitcnt_d = 4'h0;
               end else begin
                  bitcnt_d = bitcnt_q + 4'h1;
               end
            end
         end
      end else if (rx_go) begin
         busy_d    = 1'b0;
         started_d = 1'b0;
         if (trail) begin
            rsr_d = rx_full;
            if (bitcnt_q == rx_last) begin
               bitcnt_d = 4'h0;
               rx_done  = 1'b1;
               if (q.full && !rd_pop) begin
                  overrun_error_flag_d = 1'b1;
               end
               if (master) begin
                  rx_ctl_d[RX_SINGLE_CHAR_RX_ENABLE] = 1'b0;
               end
            end else begin
               bitcnt_d = bitcnt_q + 4'h1;
            end
         end
      end else begin
         busy_d    = 1'b0;
         started_d = 1'b0;
         bitcnt_d  = 4'h0;
         rsr_d     = '0;
      end
      // Port disable returns the link side to idle
      if (!serial_port_enable) begin
         hold_v_d = 1'b0;
         overrun_error_flag_d   = 1'b0;
         tsr_d    = '0;
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         tx_ctl_q  <= CTRL_RST;
         rx_ctl_q  <= CTRL_RST;
         baud_q    <= CTRL_RST;
         div_q     <= DIV_RST;
         ien_q     <= IEN_RST;
         hold_q    <= '0;
         hold_v_q  <= 1'b0;
         tsr_q     <= '0;
         busy_q    <= 1'b0;
         started_q <= 1'b0;
         bitcnt_q  <= 4'h0;
         rsr_q     <= '0;
         overrun_error_flag_q    <= 1'b0;
         mck_q     <= 1'b0;
         divcnt_q  <= DIV_RST;
      end else begin
         tx_ctl_q  <= tx_ctl_d;
         rx_ctl_q  <= rx_ctl_d;
         baud_q    <= baud_d;
         div_q     <= div_d;
         ien_q     <= ien_d;
         hold_q    <= hold_d;
         hold_v_q  <= hold_v_d;
         tsr_q     <= tsr_d;
         busy_q    <= busy_d;
         started_q <= started_d;
         bitcnt_q  <= bitcnt_d;
         rsr_q     <= rsr_d;
         overrun_error_flag_q    <= overrun_error_flag_d;
         mck_q     <= mck_d;
         divcnt_q  <= divcnt_d;
      end
   end

   // Receive character queue
   ssp_rx_fifo u_rx_fifo (
      .hclk    (hclk),
      .hresetn (hresetn),
      .q       (q)
   );

   ////////////////////////////////////////////////////////////////////////////////
   // Checks
   default clocking cb @(posedge hclk); endclocking
   default disable iff (!hresetn);

   rx_flag_set_a : assert property (q.push |=> rx_complete_flag)
      else $error("receive flag not set after character");
   irq_gate_a : assert property (irq_o |-> ien_q[IE_GLOBAL] && ien_q[IE_PERI])
      else $error("request without enables");
   rx_req_a : assert property (wake_o && !tx_buffer_free_flag |-> ien_q[IE_RX] && rx_complete_flag)
      else $error("receive wake without receive enable");
   tx_hold_a : assert property (tx_write && tx_mode && busy_q |=> hold_v_q && !tx_buffer_free_flag)
      else $error("buffer flag set while holding");
   tx_reload_a : assert property ($fell(busy_q) && tx_mode && hold_v_q |=> busy_q && tx_buffer_free_flag)
      else $error("held character not loaded");
   overrun_a : assert property (rx_done && q.full && !rd_pop |=> overrun_error_flag_q && q.full)
      else $error("overrun not flagged");
   char_len_a : assert property (rx_done |-> bitcnt_q == (rx_ctl_q[RX_NINE] ? LAST_WIDE : LAST_NARROW))
      else $error("wrong character length");
   single_char_rx_enable_clear_a : assert property (rx_done && master |=> !single_char_rx_enable)
      else $error("single receive not cleared");
   clk_stop_a : assert property (master && !rx_go && !busy_q |=> !mck_q)
      else $error("master clock running while idle");
   slave_pin_a : assert property (rx_mode |-> !dt_oe && (master || !ck_oe))
      else $error("pin driven in wrong mode");
   serial_port_enable_off_a : assert property (!serial_port_enable |=> !overrun_error_flag_q && !busy_q && q.empty)
      else $error("port disable left state");

   rx_done_c   : cover property (rx_done && !master);
   overrun_c   : cover property (rx_done && q.full && !rd_pop);
   tx_reload_c : cover property ($fell(busy_q) && hold_v_q && tx_mode);
   master_rx_c : cover property (rx_done && master && single_char_rx_enable);
endmodule // ssp_top

// ===== ssp_pkg.sv
// Shared constants for the synchronous serial port: register map, fields, reset values
package ssp_pkg;

   ////////////////////////////////////////////////////////////////////////////////
   // Register byte offsets
   localparam logic [7:0] OFS_TX_STATUS = 8'h00;
   localparam logic [7:0] OFS_RX_STATUS = 8'h04;
   localparam logic [7:0] OFS_BAUD_CTRL = 8'h08;
   localparam logic [7:0] OFS_DIV_LO    = 8'h0C;
   localparam logic [7:0] OFS_DIV_HI    = 8'h10;
   localparam logic [7:0] OFS_TX_DATA   = 8'h14;
   localparam logic [7:0] OFS_RX_DATA   = 8'h18;
   localparam logic [7:0] OFS_IRQ_CTRL  = 8'h1C;

   ////////////////////////////////////////////////////////////////////////////////
   // Transmit status and control fields
   localparam int TX_MCS       = 7;   // Master clock source
   localparam int TX_NINE      = 6;   // Nine bit transmit select
   localparam int TX_EN        = 5;   // Transmit enable
   localparam int TX_SYNC      = 4;   // Synchronous mode select
   localparam int TX_TSR_EMPTY = 1;   // Shift register empty, read only
   localparam int TX_NINTH     = 0;   // Ninth transmit bit

   // Receive status and control fields
   localparam int RX_SERIAL_PORT_ENABLE  = 7;       // Serial port enable
   localparam int RX_NINE  = 6;       // Nine bit receive select
   localparam int RX_SINGLE_CHAR_RX_ENABLE  = 5;       // Single character receive enable
   localparam int RX_CONTINUOUS_RX_ENABLE  = 4;       // Continuous receive enable
   localparam int RX_OVERRUN_ERROR_FLAG  = 1;       // Overrun error, read only
   localparam int RX_NINTH = 0;       // Ninth bit of oldest character, read only

   // Baud control fields
   localparam int BC_RX_IDLE = 6;     // Receiver idle, read only
   localparam int BC_WIDE    = 3;     // Wide baud select, stored only

   // Interrupt enable and flag fields
   localparam int IE_RX     = 0;
   localparam int IE_TX     = 1;
   localparam int IE_PERI   = 2;
   localparam int IE_GLOBAL = 3;
   localparam int IF_RX     = 4;
   localparam int IF_TX     = 5;

   ////////////////////////////////////////////////////////////////////////////////
   // Write masks and reset values
   localparam logic [7:0]  TX_WR_MASK   = 8'hF1;
   localparam logic [7:0]  RX_WR_MASK   = 8'hF0;
   localparam logic [7:0]  BAUD_WR_MASK = 8'h08;
   localparam logic [7:0]  CTRL_RST     = 8'h00;
   localparam logic [15:0] DIV_RST      = 16'h0000;
   localparam logic [3:0]  IEN_RST      = 4'h0;

   // Character geometry
   localparam int          CHAR_W      = 9;
   localparam logic [3:0]  LAST_NARROW = 4'h7;
   localparam logic [3:0]  LAST_WIDE   = 4'h8;

endpackage

// ===== ssp_fifo_if.sv
// Interface between the serial port core and its receive character queue
`timescale 1ns/1ps
interface ssp_fifo_if;
   logic       push;
   logic       pop;
   logic       flush;
   logic [8:0] wdata;
   logic [8:0] head;
   logic       full;
   logic       empty;
   modport fifo (input push, input pop, input flush, input wdata,
                 output head, output full, output empty);
   modport user (output push, output pop, output flush, output wdata,
                 input head, input full, input empty);
endinterface

// ===== ssp_rx_fifo.sv
// Two character receive queue with registered head
`timescale 1ns/1ps
module ssp_rx_fifo import ssp_pkg::*; (
   input  wire logic hclk,
   input  wire logic hresetn,
   ssp_fifo_if.fifo  q
);
   logic [CHAR_W-1:0] slot0_q, slot0_d, slot1_q, slot1_d;
   logic [1:0]        cnt_q, cnt_d;

   // Next queue contents; pop shifts slot1 forward
   always_comb begin
      slot0_d = slot0_q;
      slot1_d = slot1_q;
      cnt_d   = cnt_q;
      if (q.flush) begin
         cnt_d = 2'h0;
      end else if (q.push && q.pop && cnt_q != 2'h0) begin
         if (cnt_q == 2'h1) begin
            slot0_d = q.wdata;
         end else begin
            slot0_d = slot1_q;
            slot1_d = q.wdata;
         end
      end else if (q.push && cnt_q != 2'h2) begin
         if (cnt_q == 2'h0) begin
            slot0_d = q.wdata;
         end else begin
            slot1_d = q.wdata;
         end
         cnt_d = cnt_q + 2'h1;
      end else if (q.pop && cnt_q != 2'h0) begin
         slot0_d = slot1_q;
         cnt_d   = cnt_q - 2'h1;
      end
   end

   // Queue registers
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         slot0_q <= '0;
         slot1_q <= '0;
         cnt_q   <= 2'h0;
      end else begin
         slot0_q <= slot0_d;
         slot1_q <= slot1_d;
         cnt_q   <= cnt_d;
      end
   end

   assign q.head  = slot0_q;
   assign q.full  = (cnt_q == 2'h2);
   assign q.empty = (cnt_q == 2'h0);
endmodule // ssp_rx_fifo

// ===== ssp_peer.sv
// Link peer: drives the shared clock in slave modes and talks on the data line
`timescale 1ns/1ps
module ssp_peer (
   input  wire logic ck,
   input  wire logic dt,
   output logic      ck_drv,
   output logic      dt_drv
);
   // Clock stands low outside frames
   initial begin
      ck_drv = 1'b0;
      dt_drv = 1'b0;
   end
   // Send a character LSB first, data changes with the leading edge
   task automatic send(input logic [8:0] c, input int n);
      #7;                  // Keep link edges off the system clock edges
      for (int i = 0; i < n; i++) begin
         dt_drv = c[i];
         ck_drv = 1'b1;
         #80;
         ck_drv = 1'b0;    // Trailing edge, device samples here
         #80;
      end
      dt_drv = ~dt_drv;    // Released line shows no stale bit
   endtask
   // Clock a character out of the device, one bit per clock
   task automatic fetch(input int n, output logic [8:0] c);
      c = '0;
      #7;                  // Keep link edges off the system clock edges
      for (int i = 0; i < n; i++) begin
         ck_drv = 1'b1;
         #80;
         c[i] = dt;        // Sampled at the trailing edge
         ck_drv = 1'b0;
         #80;
      end
   endtask
   // Answer a master clock, new bit on each leading edge
   task automatic serve(input logic [8:0] c, input int n);
      for (int i = 0; i < n; i++) begin
         @(posedge ck);
         dt_drv = c[i];
      end
      @(negedge ck);
      #1 dt_drv = ~dt_drv;
   endtask
endmodule // ssp_peer

// ===== testbench.sv
// Self-checking bench for the synchronous serial port
`timescale 1ns/1ps
module testbench import ssp_pkg::*;;
   logic        hclk, hresetn, hsel, hwrite, hreadyout, hresp, ck_i, dt_i;
   logic        ck_o, ck_oe, dt_o, dt_oe, wake_o, irq_o, pck, pdt;
   logic [31:0] haddr, hwdata, hrdata;
   logic [1:0]  htrans;
   logic [8:0]  c0, c1, c2, r;
   logic [31:0] exp_q[$], sv_q[$];
   string       nm_q[$];
   int          n_mismatch, tests_run, cyc;
   event        seen_e;

   // Pin levels from all drivers
   assign ck_i = ck_oe ? ck_o : pck;
   assign dt_i = dt_oe ? dt_o : pdt;
   ssp_top DUT (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
      .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hresp(hresp),
      .hreadyout(hreadyout), .hrdata(hrdata), .ck_i(ck_i), .ck_o(ck_o), .ck_oe(ck_oe),
      .dt_i(dt_i), .dt_o(dt_o), .dt_oe(dt_oe), .wake_o(wake_o), .irq_o(irq_o));
   ssp_peer peer (.ck(ck_i), .dt(dt_i), .ck_drv(pck), .dt_drv(pdt));

   ////////////////////////////////////////////////////////////
   task automatic stop_test();
      $display("Checks %0d, mismatches %0d", tests_run, n_mismatch);
      if (n_mismatch == 0 && tests_run > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask
   task automatic check(input string n, input logic [31:0] got, input logic [31:0] exp);
      tests_run++;
      if (got !== exp) begin
         n_mismatch++;
         $display("[ERR] %s: expected %h seen %h", n, exp, got);
      end
   endtask
   // Note an expectation and hand the seen value to the monitor
   task automatic look(input string n, input logic [31:0] exp, input logic [31:0] v);
      exp_q.push_back(exp);
      nm_q.push_back(n);
      sv_q.push_back(v);
      -> seen_e;
   endtask
   // One AHB single transfer, held until hready is sampled high
   task automatic bus(input logic [7:0] a, input logic w, input logic [31:0] d);
      hsel <= 1'b1;
      haddr <= {24'h0, a};
      hwrite <= w;
      htrans <= 2'h2;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      htrans <= 2'h0;
      hwdata <= d;
      do @(posedge hclk); while (hreadyout !== 1'b1);
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      bus(a, 1'b1, d);
   endtask
   task automatic rd(input string n, input logic [7:0] a, input logic [31:0] exp);
      bus(a, 1'b0, 32'h0);
      look(n, exp, hrdata);
   endtask

   // Monitor compares each seen value with the oldest note
   always @(seen_e) begin
      while (sv_q.size() > 0) begin
         check(nm_q.pop_front(), sv_q.pop_front(), exp_q.pop_front());
      end
   end
   // Clock and hang guard
   initial begin
      hclk = 1'b0;
      forever #10 hclk = ~hclk;
   end
   always @(posedge hclk) begin
      cyc++;
      if (cyc == 5000) begin
         n_mismatch++;
         stop_test();
      end
   end

   ////////////////////////////////////////////////////////////
   initial begin
      {hresetn, hsel, haddr, htrans, hwrite, hwdata} = '0;
      void'($urandom(90134));
      repeat (3) @(posedge hclk);
      hresetn <= 1'b1;
      @(posedge hclk);
      rd("tx_status", OFS_TX_STATUS, 32'h02);
      rd("rx_status", OFS_RX_STATUS, 32'h00);
      rd("baud", OFS_BAUD_CTRL, 32'h40);
      rd("unmapped", 8'h20, 32'h00);
      c0 = 9'($urandom_range(15, 7));
      wr(OFS_DIV_LO, {23'h0, c0});
      rd("divisor", OFS_DIV_LO, {23'h0, c0});
      rd("tx_data", OFS_TX_DATA, 32'h00);
      $display("Registers test done");
      // Slave reception, overrun on third character
      wr(OFS_TX_STATUS, 32'h10);
      wr(OFS_IRQ_CTRL, 32'h05);
      wr(OFS_RX_STATUS, 32'h90);
      c0 = 9'($urandom_range(255));
      c1 = 9'($urandom_range(255));
      c2 = 9'($urandom_range(255));
      peer.send(c0, 8);
      peer.send(c1, 8);
      peer.send(c2, 8);
      repeat (5) @(posedge hclk);
      look("wake", 32'h1, {31'h0, wake_o});
      look("ck_oe", 32'h0, {31'h0, ck_oe});
      look("dt_oe", 32'h0, {31'h0, dt_oe});
      rd("rx_status", OFS_RX_STATUS, 32'h92);
      rd("rx_data", OFS_RX_DATA, {24'h0, c0[7:0]});
      look("hresp", 32'h0, {31'h0, hresp});
      rd("rx_data", OFS_RX_DATA, {24'h0, c1[7:0]});
      wr(OFS_RX_STATUS, 32'h80);
      rd("rx_status", OFS_RX_STATUS, 32'h80);
      c0 = 9'($urandom_range(511));
      wr(OFS_RX_STATUS, 32'hE0);
      peer.send(c0, 9);
      repeat (5) @(posedge hclk);
      rd("rx_status", OFS_RX_STATUS, {24'h0, 7'h70, c0[8]});
      rd("rx_data", OFS_RX_DATA, {24'h0, c0[7:0]});
      $display("Slave receive test done");
      // Slave transmission of two queued characters
      wr(OFS_RX_STATUS, 32'h80);
      wr(OFS_TX_STATUS, 32'h71);
      wr(OFS_IRQ_CTRL, 32'h06);
      c1 = 9'($urandom_range(255));
      c2 = 9'($urandom_range(255));
      wr(OFS_TX_DATA, {24'h0, c1[7:0]});
      wr(OFS_TX_DATA, {24'h0, c2[7:0]});
      rd("irq_ctrl", OFS_IRQ_CTRL, 32'h06);
      peer.fetch(9, r);
      look("char", {23'h0, 1'b1, c1[7:0]}, {23'h0, r});
      repeat (5) @(posedge hclk);
      rd("irq_ctrl", OFS_IRQ_CTRL, 32'h26);
      look("wake", 32'h1, {31'h0, wake_o});
      wr(OFS_IRQ_CTRL, 32'h0E);
      @(posedge hclk);
      look("irq", 32'h1, {31'h0, irq_o});
      peer.fetch(9, r);
      look("char", {23'h0, 1'b1, c2[7:0]}, {23'h0, r});
      $display("Slave transmit test done");
      // Master single reception
      repeat (5) @(posedge hclk);
      wr(OFS_TX_STATUS, 32'h90);
      repeat (40) @(posedge hclk);
      look("ck_idle", 32'h0, {31'h0, ck_o});
      c0 = 9'($urandom_range(255));
      wr(OFS_RX_STATUS, 32'hA0);
      peer.serve(c0, 8);
      repeat (40) @(posedge hclk);
      rd("rx_status", OFS_RX_STATUS, 32'h80);
      rd("rx_data", OFS_RX_DATA, {24'h0, c0[7:0]});
      // Master continuous reception cut in mid character
      wr(OFS_RX_STATUS, 32'h90);
      repeat (30) @(posedge hclk);
      wr(OFS_RX_STATUS, 32'h80);
      repeat (5) @(posedge hclk);
      look("ck_cut", 32'h0, {31'h0, ck_o});
      rd("irq_ctrl", OFS_IRQ_CTRL, 32'h2E);
      @(posedge hclk);
      $display("Master receive test done");
      stop_test();
   end
endmodule // testbench
